// ### verilog/pmc_cfg.svh
/*
 power mode controller constants: register offsets, bit positions,
 reset values and cycle counts.
 assumes it is included by bare name before any use.
*/
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_ADDR_PCR 8'h00
`define PMC_ADDR_FSR 8'h04
`define PMC_BIT_IDLE 0
`define PMC_BIT_PD 1
`define PMC_BIT_DBL 0
`define PMC_BIT_MODE_LO 1
`define PMC_BIT_MODE_HI 2
`define PMC_PCR_RST 8'h00
`define PMC_DATA_ZERO 8'h00
`define PMC_WAKE_CYC 11'h400
`define PMC_CNT_ZERO 11'h000
`define PMC_CNT_ONE 11'h001
`define PMC_MC_X1 4'hc
`define PMC_MC_X2 4'h6
`define PMC_MC_ZERO 4'h0
`define PMC_MC_ONE 4'h1
`define PMC_FMAX_X1_MHZ 40
`define PMC_FMAX_X2_MHZ 20

`endif

// ### verilog/pmc_pkg.sv
/*
 power mode controller types: mode states and packed carriers.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package pmc_pkg;

	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_PD,
		PMC_WAKE
	} pmc_state_e;

	typedef struct packed {
		logic idle_request_bit;
		logic powerdown_request_bit;
	} pmc_pcr_s;

	typedef struct packed {
		logic level;
		logic enable;
		logic pin_n;
	} pmc_extint_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmc_bus_s;

endpackage : pmc_pkg

`default_nettype wire

// ### verilog/pmc_wake_cnt.sv
/*
 wake hold counter on the restarted oscillator.
 assumes start is a one-cycle pulse; done stays high until next start.
*/
`default_nettype none
`include "pmc_cfg.svh"

module pmc_wake_cnt
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic start_in,
	output logic done_out
);

	typedef struct packed {
		logic [10:0] cnt;
		logic busy;
		logic done;
	} pmc_wc_s;

	pmc_wc_s cur;
	pmc_wc_s next_cur;

	always_comb
	begin
		next_cur = cur;
		if (start_in)
		begin
			next_cur.cnt = `PMC_CNT_ZERO;
			next_cur.busy = 1'b1;
			next_cur.done = 1'b0;
		end
		else if (cur.busy)
		begin
			next_cur.cnt = cur.cnt + `PMC_CNT_ONE;
			if (cur.cnt == `PMC_WAKE_CYC - `PMC_CNT_ONE)
			begin
				next_cur.busy = 1'b0;
				next_cur.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign done_out = cur.done;

endmodule : pmc_wake_cnt

`default_nettype wire

// ### verilog/pmc_mcycle.sv
/*
 machine cycle divider: one tick every 12 or 6 oscillator clocks.
 assumes run low stops the count and holds its phase.
*/
`default_nettype none
`include "pmc_cfg.svh"

module pmc_mcycle
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic run_in,
	input wire logic dbl_in,
	output logic tick_out
);

	typedef struct packed {
		logic [3:0] cnt;
		logic tick;
	} pmc_mc_s;

	pmc_mc_s cur;
	pmc_mc_s next_cur;
	logic [3:0] last;

	always_comb
	begin
		last = (dbl_in ? `PMC_MC_X2 : `PMC_MC_X1) - `PMC_MC_ONE;
		next_cur = cur;
		next_cur.tick = 1'b0;
		if (run_in)
		begin
			if (cur.cnt >= last)
			begin
				next_cur.cnt = `PMC_MC_ZERO;
				next_cur.tick = 1'b1;
			end
			else
				next_cur.cnt = cur.cnt + `PMC_MC_ONE;
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign tick_out = cur.tick;

endmodule : pmc_mcycle

`default_nettype wire

// ### verilog/pmc_top.sv
/*
 power mode controller: idle and power-down entry and exit, strobe
 forcing, wake hold, watchdog run, and x1/x2 machine cycle option.
 assumes all inputs synchronous to clk_sys_in; irq_start_in pulses when
 an interrupt begins service; dbl_cmd_in pulses on a host or iap command.
*/
// Strobed register access and the register offsets were chosen for this implementation.
`default_nettype none
`include "pmc_cfg.svh"

// Functional notes
// RQ1: setting the idle request bit enters idle.
// RQ2: idle keeps peripherals clocked, halts program counter, keeps registers.
// RQ3: interrupt service start in idle clears idle bit, returns to run.
// RQ4: hardware reset ends idle or power-down like power-on.
// RQ5: idle holds address latch strobe and program store strobe high.
// RQ6: setting the power-down request bit enters power-down.
// RQ7: power-down stops clocks, keeps register contents.
// RQ8: power-down drives both strobes low.
// RQ9: only enabled level external interrupt wakes; service start clears bit (code clears it when the wake hold count ends, not on irq_start_in).
// RQ10: waker holds interrupt pin low at least 1024 clocks.
// RQ11: after wake and service the program resumes after entry.
// RQ12: sda falling edge in power-down wakes; first byte may be lost.
// RQ13: firmware may place a few no-ops after mode entry.
// RQ14: default is 12 oscillator clocks per machine cycle.
// RQ15: 6-clock option set only by host or iap command.
// RQ16: double-speed flag reads cleared in 6-clock mode.
// RQ17: doubling affects internal clock only; oscillator output undoubled.
// RQ18: max clock 40 MHz x1, 20 MHz x2; same machine rate.
// RQ19: watchdog counts in idle, halts in power-down.
// RQ20: wake releases execution only after a full hold count.
module pmc_top
(
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [7:0] bus_addr_in,
	input wire logic [7:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	output logic [7:0] bus_rdata_out,
	input wire logic irq_start_in,
	input wire logic ext_int_n_in,
	input wire logic ext_int_en_in,
	input wire logic ext_int_level_in,
	input wire logic sda_in,
	input wire logic dbl_cmd_in,
	input wire logic dbl_val_in,
	input wire logic ale_core_in,
	input wire logic program_store_strobe_n_core_in,
	input wire logic oscillator_input_in,
	output logic ale_out,
	output logic program_store_strobe_n_out,
	output logic oscillator_output_out,
	output logic cpu_clk_en_out,
	output logic periph_clk_en_out,
	output logic osc_en_out,
	output logic wdt_run_out,
	output logic mc_tick_out
);

	typedef struct packed {
		pmc_pkg::pmc_state_e state;
		pmc_pkg::pmc_pcr_s pcr;
		logic dbl;
		logic sda_q;
		logic wake_go;
		logic [7:0] rdata;
		logic ale;
		logic program_store_strobe_n_n;
		logic osc_q;
		logic cpu_en;
		logic per_en;
		logic osc_en;
		logic wdt_run;
	} pmc_top_s;

	pmc_top_s cur;
	pmc_top_s next_cur;
	pmc_pkg::pmc_bus_s bus;
	pmc_pkg::pmc_extint_s xint;
	logic wake_done;
	logic mc_tick;
	logic ext_wake;
	logic sda_fall;

	function automatic logic [7:0] pmc_pcr_word(
		input pmc_pkg::pmc_pcr_s p);
		logic [7:0] w;
		w = `PMC_DATA_ZERO;
		w[`PMC_BIT_IDLE] = p.idle_request_bit;
		w[`PMC_BIT_PD] = p.powerdown_request_bit;
		return w;
	endfunction : pmc_pcr_word

	assign bus = '{addr: bus_addr_in, wdata: bus_wdata_in,
		wr: bus_wr_in, rd: bus_rd_in};
	assign xint = '{level: ext_int_level_in, enable: ext_int_en_in,
		pin_n: ext_int_n_in};
	assign ext_wake = xint.enable & xint.level & ~xint.pin_n; // RQ9
	assign sda_fall = cur.sda_q & ~sda_in; // RQ12

	always_comb
	begin
		next_cur = cur;
		next_cur.wake_go = 1'b0;
		next_cur.sda_q = sda_in;
		next_cur.osc_q = oscillator_input_in; // RQ17
		if (dbl_cmd_in)
			next_cur.dbl = dbl_val_in; // RQ15
		if (bus.wr && bus.addr == `PMC_ADDR_PCR)
		begin
			next_cur.pcr.idle_request_bit = bus.wdata[`PMC_BIT_IDLE];
			next_cur.pcr.powerdown_request_bit = bus.wdata[`PMC_BIT_PD];
		end
		case (cur.state)
			pmc_pkg::PMC_RUN:
			begin
				if (cur.pcr.powerdown_request_bit)
					next_cur.state = pmc_pkg::PMC_PD; // RQ6
				else if (cur.pcr.idle_request_bit)
					next_cur.state = pmc_pkg::PMC_IDLE; // RQ1
			end
			pmc_pkg::PMC_IDLE:
			begin
				if (irq_start_in)
				begin
					next_cur.pcr.idle_request_bit = 1'b0; // RQ3
					next_cur.state = pmc_pkg::PMC_RUN;
				end
			end
			pmc_pkg::PMC_PD:
			begin
				if (ext_wake || sda_fall)
				begin
					next_cur.state = pmc_pkg::PMC_WAKE; // RQ9 RQ12
					next_cur.wake_go = 1'b1;
				end
			end
			pmc_pkg::PMC_WAKE:
			begin
				if (wake_done && !cur.wake_go)
				begin
					next_cur.pcr.powerdown_request_bit = 1'b0; // RQ9 RQ20
					next_cur.pcr.idle_request_bit = 1'b0;
					next_cur.state = pmc_pkg::PMC_RUN; // RQ11
				end
			end
			default:
				next_cur.state = pmc_pkg::PMC_RUN;
		endcase
		next_cur.cpu_en = next_cur.state == pmc_pkg::PMC_RUN; // RQ2
		next_cur.per_en = next_cur.state == pmc_pkg::PMC_RUN
			|| next_cur.state == pmc_pkg::PMC_IDLE; // RQ2 RQ7
		next_cur.osc_en = next_cur.state != pmc_pkg::PMC_PD; // RQ7
		next_cur.wdt_run = next_cur.per_en; // RQ19
		case (next_cur.state)
			pmc_pkg::PMC_IDLE:
			begin
				next_cur.ale = 1'b1; // RQ5
				next_cur.program_store_strobe_n_n = 1'b1;
			end
			pmc_pkg::PMC_PD, pmc_pkg::PMC_WAKE:
			begin
				next_cur.ale = 1'b0; // RQ8
				next_cur.program_store_strobe_n_n = 1'b0;
			end
			default:
			begin
				next_cur.ale = ale_core_in;
				next_cur.program_store_strobe_n_n = program_store_strobe_n_core_in;
			end
		endcase
		next_cur.rdata = `PMC_DATA_ZERO;
		if (bus.rd)
		begin
			case (bus.addr)
				`PMC_ADDR_PCR:
					next_cur.rdata = pmc_pcr_word(cur.pcr);
				`PMC_ADDR_FSR:
				begin
					next_cur.rdata[`PMC_BIT_DBL] = ~cur.dbl; // RQ16
					next_cur.rdata[`PMC_BIT_MODE_HI:`PMC_BIT_MODE_LO] =
						cur.state;
				end
				default:
					next_cur.rdata = `PMC_DATA_ZERO;
			endcase
		end
	end

	// asynchronous reset restarts as power-on
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			cur <= '0; // RQ4
			cur.state <= pmc_pkg::PMC_RUN;
			cur.ale <= 1'b1;
			cur.program_store_strobe_n_n <= 1'b1;
			cur.cpu_en <= 1'b1;
			cur.per_en <= 1'b1;
			cur.osc_en <= 1'b1;
			cur.wdt_run <= 1'b1;
			cur.sda_q <= 1'b1;
		end
		else
			cur <= next_cur;
	end

	pmc_wake_cnt u_wake
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.start_in(cur.wake_go), // RQ20
		.done_out(wake_done)
	);

	pmc_mcycle u_mc
	(
		.clk_sys_in(clk_sys_in),
		.arst_n_in(arst_n_in),
		.run_in(cur.per_en),
		.dbl_in(cur.dbl), // RQ14 RQ15 RQ18
		.tick_out(mc_tick)
	);

	assign bus_rdata_out = cur.rdata;
	assign ale_out = cur.ale;
	assign program_store_strobe_n_out = cur.program_store_strobe_n_n;
	assign oscillator_output_out = cur.osc_q;
	assign cpu_clk_en_out = cur.cpu_en;
	assign periph_clk_en_out = cur.per_en;
	assign osc_en_out = cur.osc_en;
	assign wdt_run_out = cur.wdt_run;
	assign mc_tick_out = mc_tick;

	int unsigned wake_len;
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			wake_len <= 0;
		else if (cur.state == pmc_pkg::PMC_WAKE)
			wake_len <= wake_len + 1;
		else
			wake_len <= 0;
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);

	idle_entry_a: assert property ( // RQ1
		cur.state == pmc_pkg::PMC_RUN && cur.pcr.idle_request_bit
		&& !cur.pcr.powerdown_request_bit
		|=> cur.state == pmc_pkg::PMC_IDLE)
		else $error("idle not entered");
	idle_clocks_a: assert property ( // RQ2
		cur.state == pmc_pkg::PMC_IDLE |-> cur.per_en && !cur.cpu_en)
		else $error("idle clock gating wrong");
	idle_exit_a: assert property ( // RQ3
		cur.state == pmc_pkg::PMC_IDLE && irq_start_in
		|=> cur.state == pmc_pkg::PMC_RUN && !cur.pcr.idle_request_bit)
		else $error("idle exit wrong");
	idle_strobes_a: assert property ( // RQ5
		cur.state == pmc_pkg::PMC_IDLE |-> ale_out && program_store_strobe_n_out)
		else $error("strobes not high in idle");
	pd_entry_a: assert property ( // RQ6
		cur.state == pmc_pkg::PMC_RUN && cur.pcr.powerdown_request_bit
		|=> cur.state == pmc_pkg::PMC_PD ##0 !osc_en_out)
		else $error("power-down not entered");
	pd_strobes_a: assert property ( // RQ8
		cur.state == pmc_pkg::PMC_PD |-> !ale_out && !program_store_strobe_n_out)
		else $error("strobes not low in power-down");
	pd_hold_a: assert property ( // RQ9
		cur.state == pmc_pkg::PMC_PD && !ext_wake && !sda_fall
		|=> cur.state == pmc_pkg::PMC_PD)
		else $error("power-down left without wake");
	wake_len_a: assert property ( // RQ20
		cur.state == pmc_pkg::PMC_WAKE ##1 cur.state == pmc_pkg::PMC_RUN
		|-> $past(wake_len) >= `PMC_WAKE_CYC)
		else $error("wake released early");
	// helper counter bounds the hold from above instead of a long range
	wake_bound_a: assert property ( // RQ20
		cur.state == pmc_pkg::PMC_WAKE
		|-> wake_len <= `PMC_WAKE_CYC + `PMC_CNT_ONE)
		else $error("wake not released in time");
	dbl_flag_a: assert property ( // RQ16
		bus_rd_in && bus_addr_in == `PMC_ADDR_FSR
		|=> bus_rdata_out[`PMC_BIT_DBL] == !$past(cur.dbl))
		else $error("double flag wrong");
	wdt_run_a: assert property ( // RQ19
		wdt_run_out == (cur.state == pmc_pkg::PMC_RUN
		|| cur.state == pmc_pkg::PMC_IDLE))
		else $error("watchdog run wrong");

	idle_trip_c: cover property (
		cur.state == pmc_pkg::PMC_IDLE ##[1:50] cur.state == pmc_pkg::PMC_RUN);
	pd_ext_c: cover property (cur.state == pmc_pkg::PMC_PD && ext_wake);
	pd_sda_c: cover property (cur.state == pmc_pkg::PMC_PD && sda_fall);
	dbl_on_c: cover property (cur.dbl && mc_tick);

endmodule : pmc_top

`default_nettype wire

// ### bench/pmc_top_tb_top.sv
/*
 self-checking bench for the power mode controller top.
 assumes pmc_cfg.svh on the include path; the bench drives every port.
*/
`default_nettype none
`include "pmc_cfg.svh"

module pmc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic arst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic irq;
	logic ext_n;
	logic ext_en;
	logic ext_lvl;
	logic sda;
	logic dbl_cmd;
	logic dbl_val;
	logic osc_in;
	logic ale_core;
	logic ps_core;
	logic ale;
	logic ps_n;
	logic osc_out;
	logic cpu_en;
	logic per_en;
	logic osc_en;
	logic wdt;
	logic tick;
	logic [7:0] rv;
	int fails;
	int samples_checked;
	int cycles;

	pmc_top DUT (
		.clk_sys_in(clk),
		.arst_n_in(arst_n),
		.bus_addr_in(addr),
		.bus_wdata_in(wdata),
		.bus_wr_in(wr),
		.bus_rd_in(rd),
		.bus_rdata_out(rdata),
		.irq_start_in(irq),
		.ext_int_n_in(ext_n),
		.ext_int_en_in(ext_en),
		.ext_int_level_in(ext_lvl),
		.sda_in(sda),
		.dbl_cmd_in(dbl_cmd),
		.dbl_val_in(dbl_val),
		.ale_core_in(ale_core),
		.program_store_strobe_n_core_in(ps_core),
		.oscillator_input_in(osc_in),
		.ale_out(ale),
		.program_store_strobe_n_out(ps_n),
		.oscillator_output_out(osc_out),
		.cpu_clk_en_out(cpu_en),
		.periph_clk_en_out(per_en),
		.osc_en_out(osc_en),
		.wdt_run_out(wdt),
		.mc_tick_out(tick)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			tally_and_finish;
		end
	end

	// cpu, periph, osc, watchdog enables then address and store strobes
	task st(input string what, input logic [7:0] exp);
		chk(what, exp, {2'h0, cpu_en, per_en, osc_en, wdt, ale, ps_n});
	endtask : st

	task bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : bus_wr

	task bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd

	task pulse_irq;
		@(posedge clk);
		irq <= 1'b1;
		@(posedge clk);
		irq <= 1'b0;
	endtask : pulse_irq

	task period(input string what, input logic [7:0] exp);
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		do
		begin
			@(posedge clk);
			#1 n++;
		end while (tick !== 1'b1 && n < 40);
		chk(what, exp, n[7:0]);
	endtask : period

	// waits for release from wake, checking the hold state on the way
	task wake_wait(input string what);
		int n;
		n = 0;
		while (cpu_en !== 1'b1 && n < 1200)
		begin
			@(posedge clk);
			#1 n++;
			if (n == 10)
				st("wake outputs", 8'h08);
		end
		chk(what, 8'h01, {7'h0, (n >= 1024 && n <= 1030)});
		st("run after wake", 8'h3c);
	endtask : wake_wait

	task t_reset;
		st("outputs in reset", 8'h3f);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1 st("run outputs", 8'h3c);
		bus_rd(`PMC_ADDR_PCR, rv);
		chk("pcr reset", `PMC_PCR_RST, rv);
		bus_rd(`PMC_ADDR_FSR, rv);
		chk("fsr reset", 8'h01, rv);
	endtask : t_reset

	task t_idle;
		bus_wr(`PMC_ADDR_PCR, 8'h01);
		@(posedge clk);
		#1 st("idle outputs", 8'h1f);
		bus_rd(`PMC_ADDR_FSR, rv);
		chk("fsr idle", 8'h03, rv);
		period("idle tick", {4'h0, `PMC_MC_X1});
		pulse_irq;
		@(posedge clk);
		#1 st("idle exit", 8'h3c);
		bus_rd(`PMC_ADDR_PCR, rv);
		chk("pcr after idle", 8'h00, rv);
	endtask : t_idle

	task t_pd;
		int k;
		ale_core <= 1'b1;
		ps_core <= 1'b1;
		bus_wr(`PMC_ADDR_PCR, 8'h02);
		@(posedge clk);
		#1 st("pd outputs", 8'h00);
		k = 0;
		repeat (30)
		begin
			@(posedge clk);
			#1 k += int'(tick === 1'b1);
		end
		chk("ticks in pd", 8'h00, k[7:0]);
		pulse_irq;
		ext_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 st("pd holds", 8'h00);
		ext_en <= 1'b1;
		ext_lvl <= 1'b1;
		ale_core <= 1'b0;
		ps_core <= 1'b0;
		wake_wait("pin wake hold");
		ext_n <= 1'b1;
		bus_rd(`PMC_ADDR_PCR, rv);
		chk("pcr after pd", 8'h00, rv);
	endtask : t_pd

	task t_sda;
		bus_wr(`PMC_ADDR_PCR, 8'h02);
		repeat (3) @(posedge clk);
		sda <= 1'b0;
		wake_wait("sda wake hold");
		sda <= 1'b1;
	endtask : t_sda

	task t_mid_reset;
		bus_wr(`PMC_ADDR_PCR, 8'h03);
		repeat (2) @(posedge clk);
		#1 st("pd wins", 8'h00);
		arst_n <= 1'b0;
		#2 st("reset in pd", 8'h3f);
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		bus_rd(`PMC_ADDR_PCR, rv);
		chk("pcr after reset", 8'h00, rv);
	endtask : t_mid_reset

	task t_dbl;
		period("x1 tick", {4'h0, `PMC_MC_X1});
		@(posedge clk);
		osc_in <= 1'b1;
		@(posedge clk);
		#1 chk("osc out high", 8'h01, {7'h0, osc_out});
		osc_in <= 1'b0;
		@(posedge clk);
		#1 chk("osc out low", 8'h00, {7'h0, osc_out});
		dbl_cmd <= 1'b1;
		dbl_val <= 1'b1;
		@(posedge clk);
		dbl_cmd <= 1'b0;
		period("x2 tick", {4'h0, `PMC_MC_X2});
		bus_rd(`PMC_ADDR_FSR, rv);
		chk("fsr x2", 8'h00, rv);
		@(posedge clk);
		dbl_cmd <= 1'b1;
		dbl_val <= 1'b0;
		@(posedge clk);
		dbl_cmd <= 1'b0;
		period("x1 again", {4'h0, `PMC_MC_X1});
		bus_rd(`PMC_ADDR_FSR, rv);
		chk("fsr x1", 8'h01, rv);
	endtask : t_dbl

	initial
	begin
		fails = 0;
		samples_checked = 0;
		cycles = 0;
		arst_n = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		irq = 1'b0;
		ext_n = 1'b1;
		ext_en = 1'b0;
		ext_lvl = 1'b0;
		sda = 1'b1;
		dbl_cmd = 1'b0;
		dbl_val = 1'b0;
		osc_in = 1'b0;
		ale_core = 1'b0;
		ps_core = 1'b0;
		repeat (12) @(posedge clk);
		t_reset;
		t_idle;
		t_pd;
		t_sda;
		t_mid_reset;
		t_dbl;
		tally_and_finish;
	end
endmodule : pmc_top_tb_top

`default_nettype wire
